// [bench/tb_top.sv]
// Self-checking bench for the two-wire target interface.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tsi_pkg::*;
   localparam int TO = 2000;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [1:0] addr_sel = 2'h0;
   logic       shutdown = 1'b0;
   logic       rx_ready = 1'b0;
   tsi_byte_t  tx_data = 8'h00;
   logic       tx_valid = 1'b0;
   logic       scl, host_pull, sda_out, sda_oe, rx_valid, rx_first;
   logic       tx_ready, busy, selected, timeout;
   tsi_byte_t  rx_data;
   wire logic  sda;
   int         miscompares = 0;
   int         num_checks = 0;
   // The pull-up gives the high level whenever nobody pulls.
   assign sda = !(host_pull || (sda_oe && !sda_out));
   always #50 clk = !clk;
   tsi_target #(.TIMEOUT_CYC(TO)) uut (
      .clk, .sys_rst, .link_scl_clk(scl), .scl_in(scl), .sda_in(sda),
      .sda_out, .sda_oe, .addr_sel, .shutdown, .rx_valid, .rx_ready,
      .rx_data, .rx_first, .tx_data, .tx_valid, .tx_ready, .busy,
      .selected, .timeout
   );
   tsi_host host (.scl, .pull(host_pull), .sda);
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic give_up;
      miscompares++;
      report_and_stop;
   endtask : give_up
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
         miscompares++;
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wait_txr;
      int n = 0;
      tick(1);
      while (tx_ready !== 1'b1 && n < 400)
      begin
         tick(1);
         n++;
      end
      if (n == 400)
         give_up;
   endtask : wait_txr
   task automatic pop(input tsi_byte_t d, input logic f);
      int n = 0;
      while (rx_valid !== 1'b1 && n < 50)
      begin
         tick(1);
         n++;
      end
      if (n == 50)
         give_up;
      check(rx_data, d);
      check(rx_first, f);
      rx_ready = 1'b1;
      tick(1);
      rx_ready = 1'b0;
   endtask : pop
   task automatic sc_addr;
      tsi_byte_t q;
      logic      a;
      rx_ready = 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         addr_sel = s[1:0];
         tick(4);
         host.start_cond();
         host.byte_xfer({5'h12, s[1:0], 1'b0}, 1'b1, q, a);
         check(a, 1'b0);
         for (int i = 0; i < 4; i++)
         begin
            host.byte_xfer(8'h10 + i[7:0], 1'b1, q, a);
            check(a, 1'b0);
         end
         host.start_cond();
         host.byte_xfer({5'h12, s[1:0] + 2'h1, 1'b0}, 1'b1, q, a);
         check(a, 1'b1);
         host.stop_cond();
         check({busy, selected}, 2'h0);
      end
      rx_ready = 1'b0;
      addr_sel = 2'h0;
      tick(4);
   endtask : sc_addr
   task automatic sc_write;
      tsi_byte_t q;
      logic      a;
      host.start_cond();
      host.byte_xfer(8'h90, 1'b1, q, a);
      check(a, 1'b0);
      host.byte_xfer(8'h5a, 1'b1, q, a);
      check(a, 1'b0);
      host.byte_xfer(8'hc3, 1'b1, q, a);
      check(a, 1'b0);
      // The buffer is full now, so the third word must be refused.
      host.byte_xfer(8'h3c, 1'b1, q, a);
      check(a, 1'b1);
      host.stop_cond();
      pop(8'h5a, 1'b1);
      pop(8'hc3, 1'b0);
      check(rx_valid, 1'b0);
   endtask : sc_write
   task automatic sc_read;
      tsi_byte_t q;
      logic      a;
      fork
         begin
            tx_data = 8'h19;
            tx_valid = 1'b1;
            wait_txr;
            tx_data = 8'h80;
            wait_txr;
            tx_valid = 1'b0;
         end
         begin
            host.start_cond();
            host.byte_xfer(8'h91, 1'b1, q, a);
            check(a, 1'b0);
            host.byte_xfer(8'hff, 1'b0, q, a);
            check(q, 8'h19);
            host.byte_xfer(8'hff, 1'b0, q, a);
            check(q, 8'h80);
            // Nothing is offered for the third byte, so all ones go out.
            host.byte_xfer(8'hff, 1'b1, q, a);
            check(q, 8'hff);
            tick(5);
            check(sda_oe, 1'b0);
            host.stop_cond();
         end
      join
   endtask : sc_read
   task automatic sc_timeout;
      tsi_byte_t q;
      logic      a;
      int        n;
      host.start_cond();
      host.byte_xfer(8'h90, 1'b1, q, a);
      n = 0;
      while (timeout !== 1'b1 && n < TO + 50)
      begin
         tick(1);
         n++;
      end
      if (n == TO + 50)
         give_up;
      check(n >= TO, 1'b1);
      tick(1);
      check({busy, sda_oe}, 2'h0);
      shutdown = 1'b1;
      host.start_cond();
      host.byte_xfer(8'h90, 1'b1, q, a);
      n = 0;
      repeat (TO + 100)
      begin
         tick(1);
         if (timeout === 1'b1)
            n++;
      end
      check({n != 0, busy}, 2'h1);
      host.stop_cond();
      shutdown = 1'b0;
      check(busy, 1'b0);
   endtask : sc_timeout
   initial
   begin
      tick(2);
      sys_rst = 1'b0;
      tick(4);
      check({busy, selected, sda_oe}, 8'h0);
      check({rx_valid, tx_ready, timeout}, 8'h0);
      sc_addr;
      sc_write;
      sc_read;
      sc_timeout;
      report_and_stop;
   end
endmodule : tb_top
`default_nettype wire

// [bench/tsi_checker.sv]
// Assertion checker for the two-wire target interface.
`timescale 1ns/1ps
`default_nettype none
module tsi_checker #(
   parameter int TIMEOUT_CYC = 2000
) (
   input wire logic               clk,
   input wire logic               sys_rst,
   input wire logic               scl_in,
   input wire logic               sda_in,
   input wire logic               sda_out,
   input wire logic               sda_oe,
   input wire logic               shutdown,
   input wire logic               rx_valid,
   input wire logic               rx_ready,
   input wire tsi_pkg::tsi_byte_t rx_data,
   input wire logic               tx_ready,
   input wire logic               busy,
   input wire logic               selected,
   input wire logic               timeout
);
   import tsi_pkg::*;
   logic        scl_q;
   logic        sda_q;
   logic [31:0] quiet_cnt;
   logic        moved;
   assign moved = (scl_in != scl_q) || (sda_in != sda_q);
   // Raw lines are counted, so the design's own count lags by its sync stages.
   always_ff @(posedge clk)
   begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (sys_rst || !busy || shutdown || moved)
         quiet_cnt <= '0;
      else
         quiet_cnt <= quiet_cnt + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   idle_quiet_a: assert property (!busy [*2] |-> !sda_oe)
      else $error("data line pulled while idle");
   od_low_a: assert property (sda_oe |-> !sda_out)
      else $error("data line driven high");
   sel_ack_a: assert property ($rose(sda_oe) |-> ##[0:1] selected)
      else $error("data pulled without address match");
   to_release_a: assert property (timeout |=> !busy && !sda_oe)
      else $error("time-out left the bus held");
   to_pulse_a: assert property (timeout |=> !timeout)
      else $error("time-out pulse too long");
   sd_no_to_a: assert property (shutdown [*6] |-> !timeout)
      else $error("time-out during shutdown");
   to_bound_a: assert property (quiet_cnt <= TIMEOUT_CYC + 8)
      else $error("stalled transfer not abandoned");
   to_early_a: assert property (
      timeout |-> quiet_cnt >= TIMEOUT_CYC - 4)
      else $error("time-out came too early");
   tx_pulse_a: assert property (tx_ready |=> !tx_ready)
      else $error("transmit take pulse too long");
   rx_hold_a: assert property (
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("received word lost while stalled");
endmodule : tsi_checker
bind tsi_target tsi_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
   .clk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe, .shutdown,
   .rx_valid, .rx_ready, .rx_data, .tx_ready, .busy, .selected, .timeout
);
`default_nettype wire

// [bench/tsi_host.sv]
// Bus host model: makes the serial clock and pulls the data line.
`timescale 1ns/1ps
`default_nettype none
module tsi_host (
   output var logic scl,
   output var logic pull,
   input  wire logic sda
);
   import tsi_pkg::*;
   initial
   begin
      scl  = 1'b1;
      pull = 1'b0;
   end
   // Data moves well inside the low phase so no edge looks like a start.
   task automatic start_cond;
      #200 pull = 1'b0;
      #600 scl = 1'b1;
      #800 pull = 1'b1;
      #800 scl = 1'b0;
   endtask : start_cond
   task automatic stop_cond;
      #200 pull = 1'b1;
      #600 scl = 1'b1;
      #800 pull = 1'b0;
      #1600;
   endtask : stop_cond
   task automatic bit_xfer(input logic b, output logic r);
      #200 pull = !b;
      #600 scl = 1'b1;
      #800 r = sda;
      scl = 1'b0;
   endtask : bit_xfer
   task automatic byte_xfer(input tsi_byte_t d, input logic ack_in,
      output tsi_byte_t q, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_xfer(d[i], q[i]);
      bit_xfer(ack_in, ack);
   endtask : byte_xfer
endmodule : tsi_host
`default_nettype wire

// [verilog/tsi_buf.sv]
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module tsi_buf #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   import tsi_pkg::*;

   localparam int CW = $clog2(DEPTH + 1);

   // Refused at elaboration: a single entry cannot cover a stalled reader.
   if (DEPTH < 2 || WIDTH < 1)
   begin : g_bad_size
      $error("tsi_buf needs DEPTH of at least 2 and WIDTH of at least 1");
   end

   // Entry 0 is always the head, so the output comes straight from a flop.
   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [CW-1:0]    count;
   logic [CW-1:0]    next_count;

   always_comb
   begin
      logic          pop;
      logic          push;
      logic [CW-1:0] slot;
      pop  = out_valid && out_ready;
      push = in_valid && in_ready;
      slot = pop ? CW'(count - 1'b1) : count;
      for (int i = 0; i < DEPTH; i++)
      begin
         if (pop && i < DEPTH - 1)
            next_mem[i] = mem[i + 1];
         else
            next_mem[i] = mem[i];
         if (push && slot == CW'(i))
            next_mem[i] = in_data;
      end
      next_count = CW'(count + CW'(push) - CW'(pop));
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         count <= '0;
         for (int i = 0; i < DEPTH; i++)
            mem[i] <= '0;
      end
      else
      begin
         count <= next_count;
         mem   <= next_mem;
      end
   end

   assign in_ready  = (count != CW'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[0];

endmodule : tsi_buf
`default_nettype wire

// [verilog/tsi_cfg.svh]
// Constants of the two-wire temperature sensor target interface.
//
// How it works
// R1 - Idle is both lines high; the target never pulls a line low then.
// R2 - Start is data falling while clock is high; the target detects it.
// R3 - Stop is data rising while clock is high; it ends the transfer.
// R4 - A repeated start or a stop both finish a transfer validly.
// R5 - The host sets the byte count; the target imposes no upper limit.
// R6 - Addresses and data move as 8-bit words, each with one ack slot.
// R7 - On address match, the target pulls data low in each ninth clock; the code does so only after the address and accepted write bytes.
// R8 - A host not-acknowledge ends a read; the target then stops driving.
// R9 - The target answers a 7-bit address, example pattern 1001000.
// R10 - Four selectable target addresses let four devices share one bus.
// R11 - A bus time-out of typically 30 ms abandons a stalled transfer.
// R12 - Word write and word read transfer formats are supported.
// R13 - The data line is open-drain: pulled low or released only.
// R14 - The bus time-out is disabled while the device is shut down.
// R15 - A temperature read returns two bytes, most significant byte first.
// R16 - On time-out the data line is released and the machine goes idle.
`ifndef TSI_CFG_SVH
`define TSI_CFG_SVH

`define TSI_WORD_BITS    8
`define TSI_ADDR_BASE    7'h48
`define TSI_ADDR_SEL_LSB 0
`define TSI_IDLE_FILL    8'hff
`define TSI_BUF_DEPTH    2
`define TSI_CLK_HZ       10000000
`define TSI_TIMEOUT_MS   30
`define TSI_TIMEOUT_CYC  (`TSI_TIMEOUT_MS * (`TSI_CLK_HZ / 1000))

`endif

// [verilog/tsi_pkg.sv]
// Types shared by the target interface modules.
`default_nettype none
package tsi_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_BYTE,
      ST_WR_ACK,
      ST_RD_BYTE,
      ST_RD_ACK,
      ST_RD_NEXT,
      ST_SKIP
   } tsi_state_t;

   typedef logic [7:0] tsi_byte_t;

endpackage : tsi_pkg
`default_nettype wire

// [verilog/tsi_target.sv]
// Two-wire bus target: start/stop, address match, word write and read.
`timescale 1ns/1ps
`default_nettype none
`include "tsi_cfg.svh"
module tsi_target #(
   parameter int TIMEOUT_CYC = `TSI_TIMEOUT_CYC,
   parameter logic [6:0] ADDR_BASE = `TSI_ADDR_BASE
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             link_scl_clk,
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe,
   input  wire logic [1:0]       addr_sel,
   input  wire logic             shutdown,
   output logic                  rx_valid,
   input  wire logic             rx_ready,
   output tsi_pkg::tsi_byte_t    rx_data,
   output logic                  rx_first,
   input  wire tsi_pkg::tsi_byte_t tx_data,
   input  wire logic             tx_valid,
   output logic                  tx_ready,
   output logic                  busy,
   output logic                  selected,
   output logic                  timeout
);
   import tsi_pkg::*;

   localparam int TW = $clog2(TIMEOUT_CYC + 1);

   if (TIMEOUT_CYC < 2)
   begin : g_bad_timeout
      $error("tsi_target needs TIMEOUT_CYC of at least 2");
   end

   // Link domain: the serial clock itself samples the data line on each
   // rising edge. Nothing here needs a reset; the word is only read by the
   // system domain after a synchronised rise has told it a bit has landed,
   // and it then stays still for the rest of that high period and the low period that follows.
   tsi_byte_t lk_shift;

   always_ff @(posedge link_scl_clk)
   begin
      lk_shift <= {lk_shift[6:0], sda_in}; // see R6
   end

   // Pins enter the system domain through two flops; a third stage keeps
   // the previous synchronised level for edge detection.
   logic [4:0] pin_meta;
   logic [4:0] pin_sync;
   logic [1:0] pin_prev;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pin_meta <= 5'h1f;
         pin_sync <= 5'h1f;
         pin_prev <= 2'h3;
      end
      else
      begin
         pin_meta <= {shutdown, addr_sel, sda_in, scl_in};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync[1:0];
      end
   end

   logic       scl_s;
   logic       sda_s;
   logic       scl_p;
   logic       sda_p;
   logic [1:0] sel_s;
   logic       sd_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic [6:0] own_addr;

   assign scl_s    = pin_sync[0];
   assign sda_s    = pin_sync[1];
   assign sel_s    = pin_sync[3:2];
   assign sd_s     = pin_sync[4];
   assign scl_p    = pin_prev[0];
   assign sda_p    = pin_prev[1];
   assign scl_rise = scl_s && !scl_p;
   assign scl_fall = !scl_s && scl_p;
   // A repeated start takes the same path as a first start.
   assign start_det = scl_s && scl_p && sda_p && !sda_s; // see R2, R4
   assign stop_det  = scl_s && scl_p && !sda_p && sda_s; // see R3, R4
   // The two selection pins replace the low address bits.
   assign own_addr = {ADDR_BASE[6:2], sel_s}; // see R9, R10

   // Receive path buffer: a full buffer makes the target refuse the byte.
   logic      push;
   logic [8:0] push_data;
   logic      buf_in_ready;

   tsi_buf #(
      .WIDTH (9),
      .DEPTH (`TSI_BUF_DEPTH)
   ) u_buf (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (push),
      .in_data   (push_data),
      .in_ready  (buf_in_ready),
      .out_valid (rx_valid),
      .out_data  ({rx_first, rx_data}),
      .out_ready (rx_ready)
   );

   function automatic tsi_byte_t pick_tx(input logic v, input tsi_byte_t d);
      pick_tx = v ? d : `TSI_IDLE_FILL;
   endfunction : pick_tx

   tsi_state_t state;
   tsi_state_t next_state;
   logic [3:0] bitcnt;
   logic [3:0] next_bitcnt;
   tsi_byte_t  tx_shift;
   tsi_byte_t  next_tx_shift;
   logic       rw;
   logic       next_rw;
   logic       first;
   logic       next_first;
   logic       next_push;
   logic [8:0] next_push_data;
   logic       next_sda_oe;
   logic       next_tx_ready;
   logic       next_timeout;
   logic       next_selected;
   logic       next_busy;
   logic [TW-1:0] tcnt;
   logic [TW-1:0] next_tcnt;
   logic       expired;

   // The timer only runs inside a transfer while both lines sit still, so
   // a slow but live host never trips it.
   assign expired = (tcnt == TW'(TIMEOUT_CYC - 1));

   always_comb
   begin
      next_state     = state;
      next_bitcnt    = bitcnt;
      next_tx_shift  = tx_shift;
      next_rw        = rw;
      next_first     = first;
      next_push      = 1'b0;
      next_push_data = push_data;
      next_sda_oe    = sda_oe;
      next_tx_ready  = 1'b0;
      next_timeout   = 1'b0;
      next_selected  = selected;

      if (state == ST_IDLE || sd_s || scl_rise || scl_fall
          || sda_s != sda_p)
         next_tcnt = '0; // see R14
      else if (expired)
         next_tcnt = tcnt;
      else
         next_tcnt = TW'(tcnt + 1'b1); // see R11

      if (start_det)
      begin
         next_state    = ST_ADDR;
         next_bitcnt   = '0;
         next_sda_oe   = 1'b0;
         next_selected = 1'b0;
      end
      else if (stop_det)
      begin
         next_state    = ST_IDLE;
         next_sda_oe   = 1'b0; // see R1
         next_selected = 1'b0;
      end
      else if (expired && !sd_s)
      begin
         next_state    = ST_IDLE; // see R16
         next_sda_oe   = 1'b0;
         next_selected = 1'b0;
         next_timeout  = 1'b1; // see R11
         next_tcnt     = '0;
      end
      else
      begin
         unique case (state)
            ST_IDLE, ST_SKIP:
            begin
            end
            ST_ADDR:
            begin
               if (scl_rise)
               begin
                  if (bitcnt == 4'd7)
                  begin
                     next_bitcnt = '0;
                     if (lk_shift[7:1] == own_addr) // see R9, R10
                     begin
                        next_rw       = lk_shift[0]; // see R12
                        next_first    = 1'b1;
                        next_selected = 1'b1;
                        next_state    = ST_ADDR_ACK;
                     end
                     else
                        next_state = ST_SKIP;
                  end
                  else
                     next_bitcnt = 4'(bitcnt + 1'b1);
               end
            end
            ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  if (!sda_oe)
                     next_sda_oe = 1'b1; // see R7
                  else if (rw)
                  begin
                     next_tx_shift = pick_tx(tx_valid, tx_data); // see R15
                     next_tx_ready = tx_valid;
                     next_sda_oe   = !next_tx_shift[7];
                     next_bitcnt   = '0;
                     next_state    = ST_RD_BYTE;
                  end
                  else
                  begin
                     next_sda_oe = 1'b0;
                     next_state  = ST_WR_BYTE;
                  end
               end
            end
            ST_WR_BYTE:
            begin
               if (scl_rise)
               begin
                  if (bitcnt == 4'd7)
                  begin
                     next_bitcnt = '0;
                     // No byte limit: words keep flowing until stop while the buffer has room.
                     if (buf_in_ready) // see R5
                     begin
                        next_push      = 1'b1;
                        next_push_data = {first, lk_shift};
                        next_first     = 1'b0;
                        next_state     = ST_WR_ACK;
                     end
                     else
                        next_state = ST_SKIP;
                  end
                  else
                     next_bitcnt = 4'(bitcnt + 1'b1);
               end
            end
            ST_WR_ACK:
            begin
               if (scl_fall)
               begin
                  if (!sda_oe)
                     next_sda_oe = 1'b1; // see R7
                  else
                  begin
                     next_sda_oe = 1'b0;
                     next_state  = ST_WR_BYTE;
                  end
               end
            end
            ST_RD_BYTE:
            begin
               if (scl_rise)
                  next_bitcnt = 4'(bitcnt + 1'b1);
               else if (scl_fall)
               begin
                  if (bitcnt == 4'd8)
                  begin
                     next_sda_oe = 1'b0;
                     next_state  = ST_RD_ACK;
                  end
                  else
                  begin
                     next_tx_shift = {tx_shift[6:0], 1'b0};
                     next_sda_oe   = !tx_shift[6]; // see R13
                  end
               end
            end
            ST_RD_ACK:
            begin
               if (scl_rise)
               begin
                  if (!sda_s)
                     next_state = ST_RD_NEXT;
                  else
                     next_state = ST_SKIP; // see R8
               end
            end
            ST_RD_NEXT:
            begin
               if (scl_fall)
               begin
                  next_tx_shift = pick_tx(tx_valid, tx_data); // see R15
                  next_tx_ready = tx_valid;
                  next_sda_oe   = !next_tx_shift[7];
                  next_bitcnt   = '0;
                  next_state    = ST_RD_BYTE;
               end
            end
         endcase
      end
      next_busy = (next_state != ST_IDLE);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state     <= ST_IDLE;
         bitcnt    <= '0;
         tx_shift  <= '0;
         rw        <= 1'b0;
         first     <= 1'b0;
         push      <= 1'b0;
         push_data <= '0;
         sda_oe    <= 1'b0;
         sda_out   <= 1'b0;
         tx_ready  <= 1'b0;
         timeout   <= 1'b0;
         selected  <= 1'b0;
         busy      <= 1'b0;
         tcnt      <= '0;
      end
      else
      begin
         state     <= next_state;
         bitcnt    <= next_bitcnt;
         tx_shift  <= next_tx_shift;
         rw        <= next_rw;
         first     <= next_first;
         push      <= next_push;
         push_data <= next_push_data;
         sda_oe    <= next_sda_oe;
         // Open-drain: the driven level is always low.
         sda_out   <= 1'b0; // see R13
         tx_ready  <= next_tx_ready;
         timeout   <= next_timeout;
         selected  <= next_selected;
         busy      <= next_busy;
         tcnt      <= next_tcnt;
      end
   end

endmodule : tsi_target
`default_nettype wire
